// *** design/rie_exec.sv ***
`timescale 1ns/1ps
// Function
// - return from subroutine pops pc high byte then low byte; sp drops two.
// - after return from subroutine, fetching resumes at the restored address.
// - return from subroutine writes no status flag.
// - return from interrupt pops pc with the same high-then-low sequence.
// - return from interrupt leaves sp two lower, changes no other register.
// - return from interrupt releases the in-service level just handled.
// - return from interrupt does not restore the status word.
// - after return from interrupt, execution continues at restored address.
// - after return from interrupt one more instruction runs before vectoring.
// - opcode 8'h32 decodes as return from interrupt.
module rie_exec (
  input wire logic mclk,
  input wire logic resetn,
  input rie_pkg::rie_op_s op,
  input wire logic [7:0] sp_in,
  input wire logic [7:0] mem_rdata,
  input wire logic instr_end,
  input rie_pkg::rie_ack_s irq_ack,
  output logic busy,
  output rie_pkg::rie_mem_s mem,
  output rie_pkg::rie_restore_s restore,
  output logic status_we,
  output logic irq_inhibit,
  output logic [rie_pkg::LVL_N-1:0] in_service
);
  logic rst_meta;
  logic rst_n;

  // reset is released through two flops to keep release synchronous
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  rie_pkg::rie_state_e state;
  rie_pkg::rie_state_e next_state;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic [7:0] pc_hi;
  logic [7:0] next_pc_hi;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic is_int;
  logic next_is_int;
  logic [3:0] div;
  logic [3:0] next_div;
  logic [1:0] mcnt;
  logic [1:0] next_mcnt;
  logic hold;
  logic next_hold;
  logic seen;
  logic next_seen;
  logic accept;
  logic hit_sub;
  logic hit_int;
  logic mc_tick;
  logic int_clear;

  // decode only while idle, so a second opcode strobe is ignored when busy
  assign hit_sub = op.valid && (op.opcode == rie_pkg::OPC_SUB_RTN);
  assign hit_int = op.valid && (op.opcode == rie_pkg::OPC_INT_RTN);
  assign accept = (state == rie_pkg::ST_IDLE) && (hit_sub || hit_int);
  assign mc_tick = (div == rie_pkg::MC_LAST);

  // pop sequencer, machine cycle divider restarted at each accept
  always_comb begin
    next_state = state;
    next_ptr = ptr;
    next_pc_hi = pc_hi;
    next_pc = pc;
    next_is_int = is_int;
    next_div = mc_tick ? rie_pkg::DIV_ZERO : div + 4'h1;
    next_mcnt = mc_tick ? mcnt + 2'h1 : mcnt;
    case (state)
      rie_pkg::ST_IDLE: begin
        next_div = rie_pkg::MC_FIRST;
        next_mcnt = rie_pkg::MCNT_ZERO;
        if (accept) begin
          next_state = rie_pkg::ST_RD_HI;
          next_ptr = sp_in;
          next_is_int = hit_int;
        end
      end
      rie_pkg::ST_RD_HI: begin
        // high byte sits at the stack top and is read first
        next_state = rie_pkg::ST_CAP_HI;
        next_ptr = ptr - rie_pkg::SP_STEP;
      end
      rie_pkg::ST_CAP_HI: begin
        next_state = rie_pkg::ST_CAP_LO;
        next_pc_hi = mem_rdata;
        next_ptr = ptr - rie_pkg::SP_STEP;
      end
      rie_pkg::ST_CAP_LO: begin
        next_state = rie_pkg::ST_WAIT;
        next_pc = {pc_hi, mem_rdata};
      end
      rie_pkg::ST_WAIT: begin
        // stretch to the full two machine cycles of the instruction
        if (mc_tick && mcnt == rie_pkg::MCNT_LAST) begin
          next_state = rie_pkg::ST_DONE;
        end
      end
      rie_pkg::ST_DONE: begin
        next_state = rie_pkg::ST_IDLE;
      end
      default: begin
        next_state = rie_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rie_pkg::ST_IDLE;
      ptr <= rie_pkg::BYTE_ZERO;
      pc_hi <= rie_pkg::BYTE_ZERO;
      pc <= {rie_pkg::BYTE_ZERO, rie_pkg::BYTE_ZERO};
      is_int <= 1'b0;
      div <= rie_pkg::DIV_ZERO;
      mcnt <= rie_pkg::MCNT_ZERO;
    end else begin
      state <= next_state;
      ptr <= next_ptr;
      pc_hi <= next_pc_hi;
      pc <= next_pc;
      is_int <= next_is_int;
      div <= next_div;
      mcnt <= next_mcnt;
    end
  end

  // memory reads and the restored pc and sp; load is a one-cycle strobe
  always_comb begin
    busy = (state != rie_pkg::ST_IDLE);
    mem.rd = (state == rie_pkg::ST_RD_HI) || (state == rie_pkg::ST_CAP_HI);
    mem.addr = ptr;
    restore.load = (state == rie_pkg::ST_DONE);
    restore.pc = pc;
    restore.sp = ptr;
    // the status word is never written, by either return
    status_we = 1'b0;
  end

  assign int_clear = (state == rie_pkg::ST_DONE) && is_int;

  // inhibit vectoring from an interrupt return until the next instruction
  // has ended; a fresh interrupt return wins over a release in one cycle
  always_comb begin
    next_hold = hold;
    next_seen = seen;
    if (hold && !busy && op.valid) begin
      next_seen = 1'b1;
    end
    if (hold && seen && instr_end) begin
      next_hold = 1'b0;
      next_seen = 1'b0;
    end
    if (accept && hit_int) begin
      next_hold = 1'b1;
      next_seen = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= 1'b0;
      seen <= 1'b0;
    end else begin
      hold <= next_hold;
      seen <= next_seen;
    end
  end

  assign irq_inhibit = hold;

  rie_in_service u_in_service (
    .clk(mclk),
    .rst_n(rst_n),
    .ack(irq_ack),
    .clear(int_clear),
    .in_service(in_service)
  );

  // helper copy of the stack pointer seen at accept
  logic [7:0] start_sp;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_sp <= rie_pkg::BYTE_ZERO;
    end else if (accept) begin
      start_sp <= sp_in;
    end
  end

  localparam int A_DONE_DLY = rie_pkg::MC_CLKS * rie_pkg::RTN_MCYCLES;
  // bytes show on the read data in the second and third cycle
  localparam int A_LOAD_GAP = A_DONE_DLY - 2;
  localparam int A_HI_AGE = A_DONE_DLY - 2;
  localparam int A_LO_AGE = A_DONE_DLY - 3;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_hi_addr_first: assert property (
    (mem.rd && state == rie_pkg::ST_RD_HI) |-> mem.addr == start_sp)
    else $error("high byte not read from stack top");
  a_lo_addr_next: assert property (
    (mem.rd && state == rie_pkg::ST_CAP_HI) |->
      mem.addr == start_sp - rie_pkg::SP_STEP)
    else $error("low byte not read one below stack top");
  a_sp_minus_two: assert property (
    restore.load |->
      restore.sp == start_sp - rie_pkg::SP_STEP - rie_pkg::SP_STEP)
    else $error("stack pointer not lowered by two");
  // the popped bytes stood on the read data a fixed time before the load
  a_pc_restored: assert property (
    restore.load |->
      restore.pc == {$past(mem_rdata, A_HI_AGE), $past(mem_rdata, A_LO_AGE)})
    else $error("restored pc differs from popped bytes");
  a_two_mcycles: assert property (
    accept |-> !restore.load [*3] ##[A_LOAD_GAP:A_LOAD_GAP] restore.load)
    else $error("return did not end after two machine cycles");
  a_int_decode: assert property (
    (state == rie_pkg::ST_IDLE && hit_int) |=>
      (state == rie_pkg::ST_RD_HI && is_int))
    else $error("interrupt return opcode not decoded");
  a_no_status_wr: assert property (
    busy |-> !status_we)
    else $error("status word written by a return");
  a_inhibit_after: assert property (
    (restore.load && is_int) |-> irq_inhibit ##1 irq_inhibit)
    else $error("interrupt not held off after interrupt return");
  a_inhibit_release: assert property (
    $fell(irq_inhibit) |-> $past(instr_end) && $past(seen))
    else $error("inhibit dropped before one more instruction");
  a_clear_on_int: assert property (
    int_clear |-> restore.load && is_int)
    else $error("in-service release outside interrupt return");

  c_sub_done: cover property (restore.load && !is_int);
  c_int_done: cover property (restore.load && is_int);
  c_inhibit_end: cover property ($fell(irq_inhibit));
  c_busy_ignore: cover property (busy && op.valid);
endmodule

// *** design/rie_pkg.sv ***
package rie_pkg;
  // opcodes of the two return instructions
  localparam logic [7:0] OPC_SUB_RTN = 8'h22;
  localparam logic [7:0] OPC_INT_RTN = 8'h32;
  // one machine cycle is this many core clocks
  localparam int MC_CLKS = 12;
  localparam logic [3:0] MC_LAST = 4'hb;
  localparam logic [3:0] MC_FIRST = 4'h1;
  localparam logic [3:0] DIV_ZERO = 4'h0;
  // machine cycles taken by either return
  localparam int RTN_MCYCLES = 2;
  localparam logic [1:0] MCNT_LAST = 2'h1;
  localparam logic [1:0] MCNT_ZERO = 2'h0;
  // one pop moves the stack pointer down by this much
  localparam logic [7:0] SP_STEP = 8'h01;
  // number of interrupt priority levels
  localparam int LVL_N = 2;
  localparam logic [LVL_N-1:0] ISR_NONE = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } rie_op_s;

  typedef struct packed {
    logic rd;
    logic [7:0] addr;
  } rie_mem_s;

  typedef struct packed {
    logic load;
    logic [15:0] pc;
    logic [7:0] sp;
  } rie_restore_s;

  typedef struct packed {
    logic valid;
    logic level;
  } rie_ack_s;

  typedef enum {
    ST_IDLE,
    ST_RD_HI,
    ST_CAP_HI,
    ST_CAP_LO,
    ST_WAIT,
    ST_DONE
  } rie_state_e;
endpackage

// *** design/rie_in_service.sv ***
`timescale 1ns/1ps
module rie_in_service (
  input wire logic clk,
  input wire logic rst_n,
  input rie_pkg::rie_ack_s ack,
  input wire logic clear,
  output logic [rie_pkg::LVL_N-1:0] in_service
);
  // one-hot mask of the highest level now in service
  function automatic logic [rie_pkg::LVL_N-1:0] top_level(
    input logic [rie_pkg::LVL_N-1:0] v);
    logic [rie_pkg::LVL_N-1:0] m;
    m = rie_pkg::ISR_NONE;
    for (int i = 0; i < rie_pkg::LVL_N; i++) begin
      if (v[i]) begin
        m = rie_pkg::ISR_NONE;
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  logic [rie_pkg::LVL_N-1:0] next_in_service;
  logic [rie_pkg::LVL_N-1:0] set_mask;

  // clear the serviced level; a new acknowledge wins over the clear
  always_comb begin
    set_mask = rie_pkg::ISR_NONE;
    if (ack.valid) begin
      set_mask[ack.level] = 1'b1;
    end
    next_in_service = in_service;
    if (clear) begin
      next_in_service = in_service & ~top_level(in_service);
    end
    next_in_service = next_in_service | set_mask;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_service <= rie_pkg::ISR_NONE;
    end else begin
      in_service <= next_in_service;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_clear_top_level: assert property (
    (clear && !ack.valid) |=>
      in_service == ($past(in_service) & ~top_level($past(in_service))))
    else $error("return did not release the serviced level");
  a_set_wins: assert property (
    (ack.valid && clear) |=> in_service[$past(ack.level)])
    else $error("acknowledge lost against a clear");
endmodule

// *** design/rie_dummy_unused.sv ***
`timescale 1ns/1ps

// *** bench/rie_ram_model.sv ***
`timescale 1ns/1ps
// stack ram stand-in: the byte at address a reads back as a ^ salt
module rie_ram_model (
  input wire logic mclk,
  input rie_pkg::rie_mem_s mem,
  input wire logic [7:0] salt,
  output logic [7:0] mem_rdata
);
  logic rd_q = 1'b0;
  logic [7:0] addr_q = 8'h00;
  logic [7:0] last = 8'h00;
  // one-cycle read latency; between reads the bus shows the inverse of the
  // last byte, so a late sample can never match by luck
  // plain always: the model's regs start from declared values, not a reset
  always @(posedge mclk) begin
    rd_q <= mem.rd;
    addr_q <= mem.addr;
    if (rd_q) last <= addr_q ^ salt;
  end
  assign mem_rdata = rd_q ? (addr_q ^ salt) : ~last;
endmodule

// *** bench/return_instruction_exec_bench.sv ***
`timescale 1ns/1ps
module return_instruction_exec_bench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  rie_pkg::rie_op_s op = '0;
  logic [7:0] sp_in = 8'h00;
  logic [7:0] salt = 8'h00;
  logic [7:0] mem_rdata;
  logic instr_end = 1'b0;
  rie_pkg::rie_ack_s irq_ack = '0;
  logic busy;
  logic status_we;
  logic irq_inhibit;
  rie_pkg::rie_mem_s mem;
  rie_pkg::rie_restore_s restore;
  logic [1:0] in_service;
  logic [23:0] expq[$];
  logic [23:0] got;
  int err_total = 0;
  int checks = 0;
  localparam logic [7:0] OPC_SUB = rie_pkg::OPC_SUB_RTN;
  localparam logic [7:0] OPC_INT = rie_pkg::OPC_INT_RTN;
  localparam int LOAD_DLY = rie_pkg::MC_CLKS * rie_pkg::RTN_MCYCLES;

  // 125 MHz core clock
  always #4 mclk = ~mclk;

  rie_exec uut (.mclk(mclk), .resetn(resetn), .op(op), .sp_in(sp_in),
    .mem_rdata(mem_rdata), .instr_end(instr_end), .irq_ack(irq_ack),
    .busy(busy), .mem(mem), .restore(restore), .status_we(status_we),
    .irq_inhibit(irq_inhibit), .in_service(in_service));

  rie_ram_model ram (.mclk(mclk), .mem(mem), .salt(salt),
    .mem_rdata(mem_rdata));

  task automatic chk(input logic [23:0] g, input logic [23:0] e,
                     input string m);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one return; poke adds a stray strobe while busy, which must be dropped
  task automatic do_return(input logic [7:0] opc, input logic poke);
    int n;
    logic [7:0] sp;
    logic [7:0] s;
    sp = 8'($urandom());
    s = 8'($urandom());
    @(posedge mclk);
    op <= '{1'b1, opc};
    sp_in <= sp;
    salt <= s;
    expq.push_back({sp ^ s, (sp - 8'h01) ^ s, sp - 8'h02});
    @(posedge mclk);
    op.valid <= 1'b0;
    n = 0;
    // the stray strobe is raised and dropped on rising edges, one cycle long
    while (restore.load !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
      if (poke && (n == 4 || n == 5)) begin
        @(posedge mclk);
        op.valid <= (n == 4);
      end
    end
    chk(24'(n), 24'(LOAD_DLY), "load delay");
    if (n == 40) end_sim();
    @(negedge mclk);
    chk(busy, 1'b0, "busy after load");
  endtask

  // one interrupt vectored at level lvl
  task automatic ack(input logic lvl);
    @(posedge mclk);
    irq_ack <= '{1'b1, lvl};
    @(posedge mclk);
    irq_ack.valid <= 1'b0;
  endtask

  // result watcher: each load is matched to the oldest note
  always @(negedge mclk) begin
    if (restore.load === 1'b1) begin
      if (expq.size() == 0) begin
        chk(24'h1, 24'h0, "unexpected load");
      end else begin
        got = expq.pop_front();
        chk({restore.pc, restore.sp}, got, "pc and sp");
        chk(status_we, 1'b0, "status written");
      end
    end
  end

  initial begin
    void'($urandom(32'h619872e4));
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    // back-to-back returns of both kinds, random stack and contents
    for (int i = 0; i < 6; i++) begin
      do_return(i[0] ? OPC_INT : OPC_SUB, i[1]);
    end
    $display("test returns done");
    // flips of bits 0 to 3 of both opcodes must not start a return; bits 4 to 7
    // are left alone, bit 4 since it turns one return opcode into the other
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      op <= '{1'b1, (k[0] ? OPC_INT : OPC_SUB) ^ (8'h01 << (k >> 1))};
      @(posedge mclk);
      op.valid <= 1'b0;
      @(negedge mclk);
      chk(busy, 1'b0, "opcode taken");
    end
    $display("test opcodes done");
    // nested levels: plain return keeps them, each interrupt return drops top
    ack(1'b0);
    ack(1'b1);
    do_return(OPC_SUB, 1'b0);
    chk(in_service, 2'b11, "sub return touched level");
    do_return(OPC_INT, 1'b0);
    chk(in_service, 2'b01, "top level kept");
    @(posedge mclk);
    op <= '{1'b1, 8'h00};
    @(negedge mclk);
    chk(irq_inhibit, 1'b1, "inhibit early drop");
    @(posedge mclk);
    op.valid <= 1'b0;
    instr_end <= 1'b1;
    @(posedge mclk);
    instr_end <= 1'b0;
    @(negedge mclk);
    chk(irq_inhibit, 1'b0, "inhibit held");
    do_return(OPC_INT, 1'b0);
    chk(in_service, 2'b00, "low level kept");
    chk(24'(expq.size()), 24'h0, "missing load");
    $display("test interrupts done");
    end_sim();
  end
endmodule
